/* logic/processor_control_regs.sv */
// Processor control register group: register bank base, revision, CPU divider, power
// ----------------------------------------------------------------
// Functional notes
// - GPR address = bank base[15:4] OR (reg number << 1), bit 0 forced low
// - Bank base resets to 0x0100
// - Read-only 16-bit revision field; writes do nothing
// - CPU clock is system clock divided by speed field plus one
// - Speed setting affects only the CPU; peripheral clock stays undivided
// - Power register picks sleep or halt; other writable bits enable wake sources
// - Bits 15..12 wake on USB port 2B,2A,1B,1A transitions, no CPU interrupt; here the wake status bit still sets and drives irq when unmasked
// - Bit 11 wakes on OTG vbus-valid or id transition, on the OTG irq line
// - Bit 9 wakes on fast serial receive transition; that byte is discarded
// - Bit 8 wakes on falling SPI select; that byte is discarded
// - Bit 7 wakes on a read from the external host port
// - Bit 4 wakes on a transition of either pin wake input
// - Read-only bit 2 reports boost rail status, 1 means rails below 3.0V
// - Writing 1 to bit 1 sleeps at once; enabled wake resumes within 0.5 ms
// - Writing 1 to bit 0 halts only the CPU until an enabled interrupt
// ----------------------------------------------------------------
//
// Local design decision: register access over APB.
`include "proc_ctrl_params.svh"
`timescale 1ns/10ps
`default_nettype none

module processor_control_regs #(
    parameter int ADDR_W = 18,
    parameter logic [15:0] REVISION = 16'h0a5c, // Arbitrary value
    parameter int RESUME_CYCLES = `RESUME_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] gpr_num,
    output logic [15:0] gpr_addr,
    output logic cpu_clk_en,
    output logic core_clk_run,
    output logic cpu_halted,
    input wire logic cpu_irq_pending,
    input wire logic [3:0] usb_port_line,
    input wire logic otg_vbus_valid,
    input wire logic otg_id,
    input wire logic fast_serial_port_rx,
    input wire logic spi_slave_select_low,
    input wire logic external_host_port_read,
    input wire logic [1:0] pin_wake_input,
    input wire logic boost_rail_status,
    output logic otg_wake_irq_line,
    output logic discard_serial_byte,
    output logic discard_spi_byte,
    output logic irq
);
    localparam int RCNT_W = $clog2(RESUME_CYCLES + 1);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
        byte_addr = ADDR_W'({idx, 2'b00});
    endfunction

    function automatic proc_ctrl_pkg::reg_sel_t decode(input logic [ADDR_W-1:0] a);
        if (a == byte_addr(`IDX_GPR_BASE)) decode = proc_ctrl_pkg::SEL_GPR_BASE;
        else if (a == byte_addr(`IDX_REVISION)) decode = proc_ctrl_pkg::SEL_REVISION;
        else if (a == byte_addr(`IDX_CPU_DIV)) decode = proc_ctrl_pkg::SEL_CPU_DIV;
        else if (a == byte_addr(`IDX_POWER)) decode = proc_ctrl_pkg::SEL_POWER;
        else if (a == byte_addr(`IDX_IRQ_STATUS)) decode = proc_ctrl_pkg::SEL_IRQ_STATUS;
        else if (a == byte_addr(`IDX_IRQ_MASK)) decode = proc_ctrl_pkg::SEL_IRQ_MASK;
        else decode = proc_ctrl_pkg::SEL_NONE;
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [15:0] gpr_base, next_gpr_base;
    logic [3:0] cpu_div, next_cpu_div;
    logic [15:0] wake_en, next_wake_en;
    logic [`EV_COUNT-1:0] irq_status, next_irq_status;
    logic [`EV_COUNT-1:0] irq_mask, next_irq_mask;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr, next_irq;
    logic [15:0] next_gpr_addr;
    proc_ctrl_pkg::power_state_t pstate, next_pstate;
    logic [RCNT_W-1:0] resume_cnt, next_resume_cnt;
    logic [3:0] div_cnt, next_div_cnt;
    logic next_cpu_clk_en, next_core_clk_run, next_cpu_halted;
    logic next_otg_irq, next_discard_serial, next_discard_spi;
    logic serial_woke, next_serial_woke, spi_woke, next_spi_woke;
    logic [9:0] prev_in, cur_in;
    logic prev_boost;
    proc_ctrl_pkg::reg_sel_t sel;
    logic wr_fire, rd_fire;
    logic [15:0] power_rd;
    logic [9:0] edge_in;
    logic wake_usb, wake_otg, wake_serial, wake_spi, wake_host, wake_pin, wake_any;

    // ----------------------------------------------------------------
    // Wake source detection
    // ----------------------------------------------------------------
    assign cur_in = {usb_port_line, otg_vbus_valid, otg_id, fast_serial_port_rx,
                     spi_slave_select_low, pin_wake_input};
    assign edge_in = cur_in ^ prev_in;

    always_comb begin
        wake_usb = |(edge_in[9:6] & wake_en[`PWR_USB_LSB +: 4]);
        wake_otg = (edge_in[5] | edge_in[4]) & wake_en[`PWR_OTG_BIT];
        wake_serial = edge_in[3] & wake_en[`PWR_SERIAL_BIT];
        wake_spi = prev_in[2] & ~spi_slave_select_low & wake_en[`PWR_SPI_BIT];
        wake_host = external_host_port_read & wake_en[`PWR_HOSTPORT_BIT];
        wake_pin = |edge_in[1:0] & wake_en[`PWR_PIN_BIT];
        wake_any = wake_usb | wake_otg | wake_serial | wake_spi | wake_host | wake_pin;
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // Two-cycle access keeps prdata and pready straight from flops
    assign sel = decode(paddr);
    assign wr_fire = psel & penable & pready & pwrite;
    assign rd_fire = psel & penable & ~pready;
    // Sleep and halt bits show the live state
    assign power_rd = (wake_en & `PWR_WAKE_MASK)
                    | (16'(boost_rail_status) << `PWR_BOOST_BIT)
                    | (16'(pstate == proc_ctrl_pkg::PS_SLEEP || pstate == proc_ctrl_pkg::PS_WAKE)
                       << `PWR_SLEEP_BIT)
                    | (16'(pstate == proc_ctrl_pkg::PS_HALT) << `PWR_HALT_BIT);

    always_comb begin
        next_pready = rd_fire;
        next_prdata = prdata;
        next_pslverr = 1'b0;
        if (rd_fire) begin
            next_pslverr = (sel == proc_ctrl_pkg::SEL_NONE);
            unique case (sel)
                proc_ctrl_pkg::SEL_GPR_BASE: next_prdata = {16'h0000, gpr_base};
                proc_ctrl_pkg::SEL_REVISION: next_prdata = {16'h0000, REVISION};
                proc_ctrl_pkg::SEL_CPU_DIV: next_prdata = {28'h0000000, cpu_div};
                proc_ctrl_pkg::SEL_POWER: next_prdata = {16'h0000, power_rd};
                proc_ctrl_pkg::SEL_IRQ_STATUS: next_prdata = 32'(irq_status);
                proc_ctrl_pkg::SEL_IRQ_MASK: next_prdata = 32'(irq_mask);
                proc_ctrl_pkg::SEL_NONE: next_prdata = 32'h00000000;
            endcase
        end else if (pready) begin
            next_pslverr = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers and interrupt status
    // ----------------------------------------------------------------
    logic [`EV_COUNT-1:0] ev;
    always_comb begin
        ev = '0;
        ev[`EV_WAKE] = (pstate == proc_ctrl_pkg::PS_WAKE) && (resume_cnt == '0);
        ev[`EV_HALT_EXIT] = (pstate == proc_ctrl_pkg::PS_HALT) && cpu_irq_pending;
        ev[`EV_BOOST_BAD] = boost_rail_status & ~prev_boost;
    end

    always_comb begin
        next_gpr_base = gpr_base;
        next_cpu_div = cpu_div;
        next_wake_en = wake_en;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status;
        if (wr_fire) begin
            unique case (sel)
                proc_ctrl_pkg::SEL_GPR_BASE: next_gpr_base = pwdata[15:0] & `GPR_BASE_MASK;
                proc_ctrl_pkg::SEL_CPU_DIV: next_cpu_div = pwdata[3:0];
                proc_ctrl_pkg::SEL_POWER: next_wake_en = pwdata[15:0] & `PWR_WAKE_MASK;
                proc_ctrl_pkg::SEL_IRQ_STATUS:
                    next_irq_status = irq_status & ~pwdata[`EV_COUNT-1:0];
                proc_ctrl_pkg::SEL_IRQ_MASK: next_irq_mask = pwdata[`EV_COUNT-1:0];
                proc_ctrl_pkg::SEL_REVISION, proc_ctrl_pkg::SEL_NONE: begin
                end
            endcase
        end
        // Set wins over a simultaneous clear
        next_irq_status = next_irq_status | ev;
        next_irq = |(next_irq_status & next_irq_mask);
        next_gpr_addr = ((gpr_base & `GPR_BASE_MASK) | {11'h000, gpr_num, 1'b0}) & 16'hfffe;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gpr_base <= `RST_GPR_BASE;
            cpu_div <= `RST_CPU_DIV;
            wake_en <= `RST_POWER;
            irq_status <= '0;
            irq_mask <= '0;
            irq <= 1'b0;
            gpr_addr <= 16'h0000;
        end else begin
            gpr_base <= next_gpr_base;
            cpu_div <= next_cpu_div;
            wake_en <= next_wake_en;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            irq <= next_irq;
            gpr_addr <= next_gpr_addr;
        end
    end

    // ----------------------------------------------------------------
    // Power state machine
    // ----------------------------------------------------------------
    // Resume waits for the clock to settle; it is the longest allowed delay
    always_comb begin
        next_pstate = pstate;
        next_resume_cnt = resume_cnt;
        next_otg_irq = 1'b0;
        next_discard_serial = 1'b0;
        next_discard_spi = 1'b0;
        next_serial_woke = serial_woke;
        next_spi_woke = spi_woke;
        unique case (pstate)
            proc_ctrl_pkg::PS_RUN, proc_ctrl_pkg::PS_HALT: begin
                // Halt ends on an enabled interrupt
                if (pstate == proc_ctrl_pkg::PS_HALT && cpu_irq_pending) begin
                    next_pstate = proc_ctrl_pkg::PS_RUN;
                end
                // Sleep at once; sleep beats halt
                if (wr_fire && sel == proc_ctrl_pkg::SEL_POWER) begin
                    if (pwdata[`PWR_SLEEP_BIT]) begin
                        next_pstate = proc_ctrl_pkg::PS_SLEEP;
                    end else if (pwdata[`PWR_HALT_BIT]) begin
                        next_pstate = proc_ctrl_pkg::PS_HALT;
                    end
                end
            end
            proc_ctrl_pkg::PS_SLEEP: begin
                if (wake_any) begin
                    next_pstate = proc_ctrl_pkg::PS_WAKE;
                    next_resume_cnt = RCNT_W'(RESUME_CYCLES - 1);
                    next_otg_irq = wake_otg;
                    next_serial_woke = wake_serial;
                    next_spi_woke = wake_spi;
                end
            end
            proc_ctrl_pkg::PS_WAKE: begin
                if (resume_cnt == '0) begin
                    next_pstate = proc_ctrl_pkg::PS_RUN;
                    // Byte seen while waking is dropped
                    next_discard_serial = serial_woke;
                    next_discard_spi = spi_woke;
                    next_serial_woke = 1'b0;
                    next_spi_woke = 1'b0;
                end else begin
                    next_resume_cnt = resume_cnt - 1'b1;
                end
            end
            default: next_pstate = proc_ctrl_pkg::PS_RUN;
        endcase
    end

    // ----------------------------------------------------------------
    // CPU clock divider
    // ----------------------------------------------------------------
    always_comb begin
        next_div_cnt = div_cnt;
        next_cpu_clk_en = 1'b0;
        // Counter freezes in sleep and keeps its value
        if (pstate == proc_ctrl_pkg::PS_RUN || pstate == proc_ctrl_pkg::PS_HALT) begin
            // Terminal count reloads; >= catches a lowered setting
            if (div_cnt >= cpu_div) begin
                next_div_cnt = 4'h0;
                next_cpu_clk_en = (next_pstate == proc_ctrl_pkg::PS_RUN);
            end else begin
                next_div_cnt = div_cnt + 1'b1;
            end
        end
        // Peripherals keep the undivided clock outside sleep
        next_core_clk_run = (next_pstate == proc_ctrl_pkg::PS_RUN
                             || next_pstate == proc_ctrl_pkg::PS_HALT);
        next_cpu_halted = (next_pstate == proc_ctrl_pkg::PS_HALT);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pstate <= proc_ctrl_pkg::PS_RUN;
            resume_cnt <= '0;
            div_cnt <= 4'h0;
            cpu_clk_en <= 1'b0;
            core_clk_run <= 1'b1;
            cpu_halted <= 1'b0;
            otg_wake_irq_line <= 1'b0;
            discard_serial_byte <= 1'b0;
            discard_spi_byte <= 1'b0;
            serial_woke <= 1'b0;
            spi_woke <= 1'b0;
            prev_in <= 10'h000;
            prev_boost <= 1'b0;
        end else begin
            pstate <= next_pstate;
            resume_cnt <= next_resume_cnt;
            div_cnt <= next_div_cnt;
            cpu_clk_en <= next_cpu_clk_en;
            core_clk_run <= next_core_clk_run;
            cpu_halted <= next_cpu_halted;
            otg_wake_irq_line <= next_otg_irq;
            discard_serial_byte <= next_discard_serial;
            discard_spi_byte <= next_discard_spi;
            serial_woke <= next_serial_woke;
            spi_woke <= next_spi_woke;
            prev_in <= cur_in;
            prev_boost <= boost_rail_status;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    AST_GPR_ADDR: assert property (
        $past(arst_n) |-> gpr_addr == ((($past(gpr_base) & 16'hfff0)
            | {11'h000, $past(gpr_num), 1'b0}) & 16'hfffe)
    ) else $error("gpr address wrong");

    AST_REV_RO: assert property (
        (rd_fire && sel == proc_ctrl_pkg::SEL_REVISION) |=> prdata[15:0] == REVISION
    ) else $error("revision readback wrong");

    AST_DIV_PERIOD: assert property (
        (cpu_clk_en && pstate == proc_ctrl_pkg::PS_RUN && cpu_div == 4'h1
         && $stable(cpu_div)) |=> !cpu_clk_en
    ) else $error("cpu enable too frequent");

    AST_PERIPH_CLK: assert property (
        (pstate == proc_ctrl_pkg::PS_HALT) |=> core_clk_run
    ) else $error("peripheral clock stopped in halt");

    AST_SLEEP_ENTRY: assert property (
        (wr_fire && sel == proc_ctrl_pkg::SEL_POWER && pwdata[1]
         && pstate == proc_ctrl_pkg::PS_RUN) |=> ##1 !core_clk_run && !cpu_clk_en
    ) else $error("sleep not entered");

    AST_USB_NO_IRQ: assert property (
        (pstate == proc_ctrl_pkg::PS_SLEEP && wake_usb && !wake_otg) |=> !otg_wake_irq_line
    ) else $error("usb wake raised otg irq");

    AST_OTG_IRQ: assert property (
        (pstate == proc_ctrl_pkg::PS_SLEEP && wake_otg) |=> otg_wake_irq_line
    ) else $error("otg wake missing irq");

    AST_HOST_WAKE: assert property (
        (pstate == proc_ctrl_pkg::PS_SLEEP && wake_host) |=> pstate == proc_ctrl_pkg::PS_WAKE
    ) else $error("host read did not wake");

    AST_HALT_EXIT: assert property (
        (pstate == proc_ctrl_pkg::PS_HALT && cpu_irq_pending
         && !(wr_fire && sel == proc_ctrl_pkg::SEL_POWER)) |=> !cpu_halted
    ) else $error("halt not left on interrupt");

    AST_RESERVED_ZERO: assert property (
        (rd_fire && sel == proc_ctrl_pkg::SEL_CPU_DIV) |=> prdata[31:4] == 28'h0000000
    ) else $error("reserved bits not zero");

endmodule // processor_control_regs
`default_nettype wire

/* shared/proc_ctrl_params.svh */
// Offsets, field positions, reset values and timing counts of the processor control block
`ifndef PROC_CTRL_PARAMS_SVH
`define PROC_CTRL_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_GPR_BASE 16'hc002
`define IDX_REVISION 16'hc004
`define IDX_CPU_DIV 16'hc008
`define IDX_POWER 16'hc00a
`define IDX_IRQ_STATUS 16'hc0f0
`define IDX_IRQ_MASK 16'hc0f2

// ----------------------------------------------------------------
// Reset values and field layout
// ----------------------------------------------------------------
`define RST_GPR_BASE 16'h0100
`define RST_CPU_DIV 4'hf
`define RST_POWER 16'h0000
`define GPR_BASE_MASK 16'hfff0
`define PWR_WAKE_MASK 16'hfb90
`define PWR_USB_LSB 12
`define PWR_OTG_BIT 11
`define PWR_SERIAL_BIT 9
`define PWR_SPI_BIT 8
`define PWR_HOSTPORT_BIT 7
`define PWR_PIN_BIT 4
`define PWR_BOOST_BIT 2
`define PWR_SLEEP_BIT 1
`define PWR_HALT_BIT 0
`define EV_WAKE 0
`define EV_HALT_EXIT 1
`define EV_BOOST_BAD 2
`define EV_COUNT 3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ 25
`define RESUME_MAX_US 500
`define RESUME_CYCLES (`RESUME_MAX_US * `CLK_MHZ)

`endif

/* shared/proc_ctrl_pkg.sv */
// Types shared by the processor control block
package proc_ctrl_pkg;
    typedef enum logic [3:0] {
        PS_RUN = 4'h1,
        PS_HALT = 4'h2,
        PS_SLEEP = 4'h4,
        PS_WAKE = 4'h8
    } power_state_t;

    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_GPR_BASE,
        SEL_REVISION,
        SEL_CPU_DIV,
        SEL_POWER,
        SEL_IRQ_STATUS,
        SEL_IRQ_MASK
    } reg_sel_t;
endpackage

/* test/processor_control_regs_test.sv */
// Self-checking bench for the processor control register group
`include "proc_ctrl_params.svh"
`timescale 1ns/10ps
`default_nettype none

module processor_control_regs_test;
    logic clk, arst_n, psel, penable, pwrite, cpu_irq_pending, otg_vbus_valid, otg_id;
    logic fast_serial_port_rx, spi_slave_select_low, external_host_port_read, boost_rail_status;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, cpu_clk_en, core_clk_run, cpu_halted, otg_wake_irq_line, irq;
    logic discard_serial_byte, discard_spi_byte;
    logic [15:0] gpr_addr;
    logic [3:0] gpr_num, usb_port_line;
    logic [1:0] pin_wake_input;
    int fails, num_checks, otg_cnt, ser_cnt, spi_cnt;
    localparam logic [15:0] REV = 16'h3c5a; // Arbitrary value

    processor_control_regs #(.REVISION(REV), .RESUME_CYCLES(8)) uut (.clk(clk), .arst_n(arst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .gpr_num(gpr_num),
        .gpr_addr(gpr_addr), .cpu_clk_en(cpu_clk_en), .core_clk_run(core_clk_run),
        .cpu_halted(cpu_halted), .cpu_irq_pending(cpu_irq_pending),
        .usb_port_line(usb_port_line), .otg_vbus_valid(otg_vbus_valid), .otg_id(otg_id),
        .fast_serial_port_rx(fast_serial_port_rx), .spi_slave_select_low(spi_slave_select_low),
        .external_host_port_read(external_host_port_read), .pin_wake_input(pin_wake_input),
        .boost_rail_status(boost_rail_status), .otg_wake_irq_line(otg_wake_irq_line),
        .discard_serial_byte(discard_serial_byte), .discard_spi_byte(discard_spi_byte), .irq(irq));

    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end

    // Pulse outputs last one cycle, so count them at every edge
    always @(posedge clk) begin
        if (otg_wake_irq_line === 1'b1) otg_cnt++;
        if (discard_serial_byte === 1'b1) ser_cnt++;
        if (discard_spi_byte === 1'b1) spi_cnt++;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [15:0] i, input logic [15:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {i, 2'b00};
        // Reserved bits always written as zero
        pwdata <= {16'h0000, d};
        @(posedge clk);
        penable <= 1'b1;
        // Wait for the answer; only the watchdog ends a hung transfer
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] i, input logic [15:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, i, d, r, e);
    endtask

    task automatic rchk(input string nm, input logic [15:0] i, input logic [31:0] exp,
                        input logic experr);
        logic [31:0] r;
        logic e;
        apb(1'b0, i, 16'h0000, r, e);
        chk(nm, exp, r);
        chk("pslverr", {31'h0, experr}, {31'h0, e});
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic reset_values();
        chk("gpr_addr", 32'h0000011c, {16'h0, gpr_addr});
        rchk("bank_base", `IDX_GPR_BASE, 32'h00000100, 1'b0);
        rchk("cpu_div", `IDX_CPU_DIV, 32'h0000000f, 1'b0);
        rchk("power", `IDX_POWER, 32'h00000000, 1'b0);
        wr(`IDX_REVISION, 16'h0000);
        rchk("revision", `IDX_REVISION, {16'h0, REV}, 1'b0);
        rchk("unmapped", 16'hc006, 32'h00000000, 1'b1);
    endtask

    task automatic gpr_check(input logic [15:0] base, input logic [3:0] n, input logic [15:0] exp);
        wr(`IDX_GPR_BASE, base);
        gpr_num <= n;
        repeat (3) @(negedge clk);
        chk("gpr_addr", {16'h0, exp}, {16'h0, gpr_addr});
    endtask

    task automatic div_check(input logic [3:0] s);
        int n;
        wr(`IDX_CPU_DIV, {12'h000, s});
        repeat (40) @(negedge clk);
        n = 0;
        while (cpu_clk_en !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (cpu_clk_en !== 1'b1 && n < 40);
        chk("cpu_clk_period", s + 1, n);
    endtask

    task automatic wake_check(input int b);
        int n;
        wr(`IDX_POWER, (16'h0001 << b) | 16'h0002);
        repeat (2) @(negedge clk);
        chk("core_clk_run", 0, core_clk_run);
        // A source that is not enabled must leave the core asleep
        @(posedge clk);
        if (b != 4) pin_wake_input[0] <= ~pin_wake_input[0];
        repeat (3) @(negedge clk);
        chk("core_clk_run", 0, core_clk_run);
        @(posedge clk);
        case (b)
            11: otg_id <= ~otg_id;
            9: fast_serial_port_rx <= ~fast_serial_port_rx;
            8: spi_slave_select_low <= 1'b0;
            7: external_host_port_read <= 1'b1;
            4: pin_wake_input[1] <= ~pin_wake_input[1];
            default: usb_port_line <= usb_port_line ^ (4'h1 << (b - 12));
        endcase
        n = 0;
        while (core_clk_run !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        chk("core_clk_run", 1, core_clk_run);
        @(posedge clk);
        spi_slave_select_low <= 1'b1;
        external_host_port_read <= 1'b0;
        rchk("power", `IDX_POWER, 32'h1 << b, 1'b0);
        rchk("status", `IDX_IRQ_STATUS, 32'h00000001, 1'b0);
        wr(`IDX_IRQ_STATUS, 16'h0001);
    endtask

    task automatic halt_check();
        int n;
        wr(`IDX_POWER, 16'h0001);
        rchk("power", `IDX_POWER, 32'h00000001, 1'b0);
        n = 0;
        repeat (20) begin
            @(negedge clk);
            if (cpu_clk_en === 1'b1) n++;
        end
        chk("cpu_halted", 1, cpu_halted);
        chk("core_clk_run", 1, core_clk_run);
        chk("halt_enables", 0, n);
        @(posedge clk);
        cpu_irq_pending <= 1'b1;
        repeat (3) @(negedge clk);
        chk("cpu_halted", 0, cpu_halted);
        @(posedge clk);
        cpu_irq_pending <= 1'b0;
        rchk("status", `IDX_IRQ_STATUS, 32'h00000002, 1'b0);
        wr(`IDX_IRQ_STATUS, 16'h0002);
    endtask

    task automatic boost_irq_check();
        boost_rail_status <= 1'b1;
        repeat (3) @(negedge clk);
        rchk("power", `IDX_POWER, 32'h00000004, 1'b0);
        chk("irq", 0, irq);
        wr(`IDX_IRQ_MASK, 16'h0004);
        repeat (2) @(negedge clk);
        chk("irq", 1, irq);
        @(posedge clk);
        boost_rail_status <= 1'b0;
        wr(`IDX_IRQ_STATUS, 16'h0004);
        repeat (2) @(negedge clk);
        chk("irq", 0, irq);
        rchk("status", `IDX_IRQ_STATUS, 32'h00000000, 1'b0);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        automatic int wb[9] = '{15, 14, 13, 12, 11, 9, 8, 7, 4};
        automatic logic [3:0] sp[4] = '{4'h0, 4'h1, 4'h2, 4'hf};
        {arst_n, psel, penable, pwrite, cpu_irq_pending, otg_vbus_valid, otg_id} = '0;
        {fast_serial_port_rx, external_host_port_read, boost_rail_status} = '0;
        spi_slave_select_low = 1'b1;
        paddr = '0;
        pwdata = '0;
        gpr_num = 4'he;
        usb_port_line = 4'h0;
        pin_wake_input = 2'h0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(negedge clk);
        reset_values();
        gpr_check(16'habc0, 4'h5, 16'habca);
        gpr_check(16'hfff0, 4'hf, 16'hfffe);
        foreach (sp[k]) div_check(sp[k]);
        foreach (wb[k]) wake_check(wb[k]);
        chk("otg_pulses", 1, otg_cnt);
        chk("serial_discards", 1, ser_cnt);
        chk("spi_discards", 1, spi_cnt);
        halt_check();
        boost_irq_check();
        finish_test();
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        finish_test();
    end
endmodule // processor_control_regs_test

`default_nettype wire
